// ===== rtl/timer_irq_enable_gating.sv
/*
 Interrupt-enable gating of a six-channel 16-bit timer: per-channel
 enable registers, status flags, request outputs, converter trigger and
 a summary interrupt, all reached over AXI4-Lite.
 Assumes counter values and compare events come from logic on aclk.
*/
// Notes on behaviour
// [R1] six readable, writable 8-bit enable registers
// [R2] bit 7 gates converter start on A
// [R3] bit 6 reads one, writes ignored
// [R4] bit 5 gates the underflow request
// [R5] bit 5 absent in channels 0, 3
// [R6] bit 4 gates the overflow request
// [R7] bit 3 gates the compare-D request
// [R8] bit 3 absent in channels 1,2,4,5
// [R9] bit 2 gates the compare-C request
// [R10] bit 2 absent in channels 1,2,4,5
// [R11] bit 1 gates the compare-B request
// [R12] bit 0 gates the compare-A request
// [R13] overflow flag on counter ffff to 0000
// [R14] underflow flag on counter 0000 to ffff
// [R15] flag clears only by read-one, write-zero
// [R16] request follows enable and flag, drops next cycle
`timescale 1ns/1ps
`default_nettype none
module timer_irq_enable_gating (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // timer core
    input wire logic [5:0][15:0] chan_counter,
    input wire logic [5:0][3:0] cmp_evt,
    // requests
    output logic [5:0] underflow_irq_req,
    output logic [5:0] overflow_irq_req,
    output logic [5:0] cmp_d_irq_req,
    output logic [5:0] cmp_c_irq_req,
    output logic [5:0] cmp_b_irq_req,
    output logic [5:0] cmp_a_irq_req,
    output logic [5:0] conv_start_req,
    output logic irq
);
    localparam int N = tmr_pkg::NCH;

    logic wr_stb;
    tmr_pkg::wr_req_t wr;
    logic wr_err;
    logic rd_stb;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    tmr_pkg::dec_t wdec;
    tmr_pkg::dec_t rdec;

    logic [7:0] en_q [N];
    tmr_pkg::chan_flags_t flags [N];
    tmr_pkg::chan_flags_t set_ev [N];
    tmr_pkg::chan_flags_t req_q [N];
    logic [15:0] cnt_prev_q [N];
    logic [5:0] cnt_seen_q;
    logic [5:0] w_en_hit;
    logic [5:0] w_st_hit;
    logic [5:0] r_st_hit;
    logic [5:0] req_any;
    logic [5:0] req_any_q;
    logic [5:0] conv_q;
    logic [5:0] pend_q;
    logic [5:0] mask_q;
    logic [5:0] pend_clr;
    logic w_pend;
    logic w_mask;
    logic irq_q;

    axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_stb(wr_stb),
        .wr(wr),
        .wr_err(wr_err),
        .rd_stb(rd_stb),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // address decode
    assign wdec = tmr_pkg::decode(wr.addr);
    assign rdec = tmr_pkg::decode(rd_addr);
    assign wr_err = (wdec.kind == tmr_pkg::REG_NONE);
    assign rd_err = (rdec.kind == tmr_pkg::REG_NONE);
    assign w_pend = wr_stb & wr.strb[0] & (wdec.kind == tmr_pkg::REG_IRQ)
        & ~wdec.idx[0];
    assign w_mask = wr_stb & wr.strb[0] & (wdec.kind == tmr_pkg::REG_IRQ)
        & wdec.idx[0];
    assign pend_clr = w_pend ? wr.data[5:0] : 6'h00;

    // read mux; fixed bits are forced here, never stored
    always_comb begin
        rd_data = 32'h0;
        case (rdec.kind)
            tmr_pkg::REG_EN: begin
                rd_data[7:0] = en_q[rdec.idx] | tmr_pkg::EN_RSV_ONE; // R3
            end
            tmr_pkg::REG_ST: begin
                rd_data[7:0] = tmr_pkg::ST_RSV_ONE | {2'h0, flags[rdec.idx]};
            end
            tmr_pkg::REG_IRQ: begin
                rd_data[5:0] = rdec.idx[0] ? mask_q : pend_q;
            end
            default: begin
                rd_data = 32'h0;
            end
        endcase
    end

    for (genvar n = 0; n < N; n++) begin : g_ch
        localparam logic [7:0] WMASK = tmr_pkg::en_wmask(n);
        localparam logic [5:0] IMPL = {tmr_pkg::HAS_UNF[n], 1'b1,
            tmr_pkg::HAS_CD[n], tmr_pkg::HAS_CD[n], 2'h3};

        assign w_en_hit[n] = wr_stb & wr.strb[0]
            & (wdec.kind == tmr_pkg::REG_EN) & (wdec.idx == 3'(n));
        assign w_st_hit[n] = wr_stb & wr.strb[0]
            & (wdec.kind == tmr_pkg::REG_ST) & (wdec.idx == 3'(n));
        assign r_st_hit[n] = rd_stb
            & (rdec.kind == tmr_pkg::REG_ST) & (rdec.idx == 3'(n));

        // absent and reserved bits never store a one
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                en_q[n] <= tmr_pkg::EN_RST;
            end else if (w_en_hit[n]) begin
                en_q[n] <= wr.data[7:0] & WMASK; // R1 R3 R5 R8 R10
            end
        end

        // first sample after reset only primes the wrap detector
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cnt_prev_q[n] <= tmr_pkg::CNT_ZERO;
                cnt_seen_q[n] <= 1'b0;
            end else begin
                cnt_prev_q[n] <= chan_counter[n];
                cnt_seen_q[n] <= 1'b1;
            end
        end

        always_comb begin
            set_ev[n].ovf = cnt_seen_q[n] & (cnt_prev_q[n] == tmr_pkg::CNT_MAX)
                & (chan_counter[n] == tmr_pkg::CNT_ZERO); // R13
            set_ev[n].unf = cnt_seen_q[n] & (cnt_prev_q[n] == tmr_pkg::CNT_ZERO)
                & (chan_counter[n] == tmr_pkg::CNT_MAX); // R14
            set_ev[n].d = cmp_evt[n][3];
            set_ev[n].c = cmp_evt[n][2];
            set_ev[n].b = cmp_evt[n][1];
            set_ev[n].a = cmp_evt[n][0];
        end

        chan_flags #(
            .IMPL(IMPL)
        ) u_flags (
            .aclk(aclk),
            .aresetn(aresetn),
            .set(set_ev[n]),
            .rd_stb(r_st_hit[n]),
            .wr_stb(w_st_hit[n]),
            .wr_val(wr.data[5:0]),
            .flags(flags[n])
        );

        // enable bits 5..0 line up with flag bits 5..0
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                req_q[n] <= '0;
            end else begin
                req_q[n] <= tmr_pkg::chan_flags_t'(en_q[n][5:0] & flags[n]); // R16
            end
        end

        assign underflow_irq_req[n] = req_q[n].unf; // R4
        assign overflow_irq_req[n] = req_q[n].ovf; // R6
        assign cmp_d_irq_req[n] = req_q[n].d; // R7
        assign cmp_c_irq_req[n] = req_q[n].c; // R9
        assign cmp_b_irq_req[n] = req_q[n].b; // R11
        assign cmp_a_irq_req[n] = req_q[n].a; // R12
        assign req_any[n] = |(en_q[n][5:0] & flags[n]);

        // trigger is a pulse per event, not a level
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                conv_q[n] <= 1'b0;
            end else begin
                conv_q[n] <= en_q[n][tmr_pkg::TRIG_BIT] & cmp_evt[n][0]; // R2
            end
        end

        a_trig_on_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
            (cmp_evt[n][0] && en_q[n][tmr_pkg::TRIG_BIT]) |=> conv_start_req[n])
            else $error("converter start missing");
        a_trig_off: assert property (@(posedge aclk) disable iff (!aresetn) // R2
            !en_q[n][tmr_pkg::TRIG_BIT] |=> !conv_start_req[n])
            else $error("converter start while disabled");
        a_en_write: assert property (@(posedge aclk) disable iff (!aresetn) // R1
            w_en_hit[n] |=> ##1 (rd_data[7:0] == ($past(wr.data[7:0], 2) & WMASK
            | tmr_pkg::EN_RSV_ONE)) || !(rdec.kind == tmr_pkg::REG_EN
            && rdec.idx == 3'(n)))
            else $error("enable readback wrong");
        a_unf_absent: assert property (@(posedge aclk) disable iff (!aresetn) // R5
            !tmr_pkg::HAS_UNF[n] |-> (!en_q[n][5] && !underflow_irq_req[n]))
            else $error("underflow bit present");
        a_d_absent: assert property (@(posedge aclk) disable iff (!aresetn) // R8
            !tmr_pkg::HAS_CD[n] |-> (!en_q[n][3] && !cmp_d_irq_req[n]))
            else $error("compare d bit present");
        a_c_absent: assert property (@(posedge aclk) disable iff (!aresetn) // R10
            !tmr_pkg::HAS_CD[n] |-> (!en_q[n][2] && !cmp_c_irq_req[n]))
            else $error("compare c bit present");
        a_ovf_flag: assert property (@(posedge aclk) disable iff (!aresetn) // R13
            (cnt_seen_q[n] && cnt_prev_q[n] == tmr_pkg::CNT_MAX
            && chan_counter[n] == tmr_pkg::CNT_ZERO) |=> flags[n].ovf)
            else $error("overflow flag not set");
        a_unf_flag: assert property (@(posedge aclk) disable iff (!aresetn) // R14
            (tmr_pkg::HAS_UNF[n] && cnt_seen_q[n]
            && cnt_prev_q[n] == tmr_pkg::CNT_ZERO
            && chan_counter[n] == tmr_pkg::CNT_MAX) |=> flags[n].unf)
            else $error("underflow flag not set");
        a_ovf_req: assert property (@(posedge aclk) disable iff (!aresetn) // R6
            (set_ev[n].ovf && en_q[n][4] && !wr_stb) |-> ##2 overflow_irq_req[n])
            else $error("overflow request missing");
        a_unf_req: assert property (@(posedge aclk) disable iff (!aresetn) // R4
            (set_ev[n].unf && en_q[n][5] && !wr_stb) |-> ##2 underflow_irq_req[n])
            else $error("underflow request missing");
        a_d_req: assert property (@(posedge aclk) disable iff (!aresetn) // R7
            (cmp_evt[n][3] && en_q[n][3] && !wr_stb) |-> ##2 cmp_d_irq_req[n])
            else $error("compare d request missing");
        a_c_req: assert property (@(posedge aclk) disable iff (!aresetn) // R9
            (cmp_evt[n][2] && en_q[n][2] && !wr_stb) |-> ##2 cmp_c_irq_req[n])
            else $error("compare c request missing");
        a_b_req: assert property (@(posedge aclk) disable iff (!aresetn) // R11
            (cmp_evt[n][1] && en_q[n][1] && !wr_stb) |-> ##2 cmp_b_irq_req[n])
            else $error("compare b request missing");
        a_a_req: assert property (@(posedge aclk) disable iff (!aresetn) // R12
            (cmp_evt[n][0] && en_q[n][0] && !wr_stb) |-> ##2 cmp_a_irq_req[n])
            else $error("compare a request missing");
        a_req_drop: assert property (@(posedge aclk) disable iff (!aresetn) // R16
            (overflow_irq_req[n] && !(en_q[n][4] && flags[n].ovf))
            |=> !overflow_irq_req[n])
            else $error("request held after cause gone");
    end

    assign conv_start_req = conv_q;

    // summary: a channel pends when its enabled, set flags go from none to at least one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_any_q <= 6'h00;
            pend_q <= tmr_pkg::PEND_RST;
        end else begin
            req_any_q <= req_any;
            pend_q <= (pend_q & ~pend_clr) | (req_any & ~req_any_q);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= tmr_pkg::MASK_RST;
        end else if (w_mask) begin
            mask_q <= wr.data[5:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(pend_q & mask_q);
        end
    end

    assign irq = irq_q;

    a_rsv_read_one: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        (rd_stb && rdec.kind == tmr_pkg::REG_EN) |=> (rvalid && rdata[6]))
        else $error("reserved bit read as zero");
    a_irq_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        (|(pend_q & mask_q)) |=> irq)
        else $error("interrupt not raised");
    a_irq_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        !(|(pend_q & mask_q)) |=> !irq)
        else $error("interrupt without cause");

    c_trig_fire: cover property (@(posedge aclk) disable iff (!aresetn)
        |conv_start_req);
    c_ovf_req: cover property (@(posedge aclk) disable iff (!aresetn)
        |overflow_irq_req);
    c_flag_clear: cover property (@(posedge aclk) disable iff (!aresetn)
        |w_st_hit ##1 !flags[0].a);
    c_irq_out: cover property (@(posedge aclk) disable iff (!aresetn)
        !irq ##1 irq);
endmodule : timer_irq_enable_gating
`default_nettype wire

// ===== inc/tmr_pkg.sv
/*
 Shared constants, types and the address decoder of the six-channel
 timer interrupt-enable block. Assumes an 8-bit byte address from an
 AXI4-Lite slave and 32-bit data words.
*/
package tmr_pkg;
    localparam int NCH = 6;
    localparam logic [2:0] NCH_IDX = 3'h6;
    // register byte offsets
    localparam logic [7:0] EN_BASE = 8'h00;
    localparam logic [7:0] ST_BASE = 8'h20;
    localparam logic [7:0] IRQ_ST_OFF = 8'h40;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h44;
    // enable register field positions
    localparam int TRIG_BIT = 7;
    localparam int RSV_BIT = 6;
    localparam int UNF_BIT = 5;
    localparam int OVF_BIT = 4;
    localparam int D_BIT = 3;
    localparam int C_BIT = 2;
    localparam int B_BIT = 1;
    localparam int A_BIT = 0;
    // values after reset and fixed bits
    localparam logic [7:0] EN_RST = 8'h00;
    localparam logic [7:0] EN_RSV_ONE = 8'h40;
    localparam logic [7:0] ST_RSV_ONE = 8'hc0;
    localparam logic [5:0] FLAG_RST = 6'h00;
    localparam logic [5:0] PEND_RST = 6'h00;
    localparam logic [5:0] MASK_RST = 6'h00;
    // writable enable bits
    localparam logic [7:0] EN_WR_COMMON = 8'h93;
    localparam logic [7:0] EN_WR_UNF = 8'h20;
    localparam logic [7:0] EN_WR_CD = 8'h0c;
    // channels owning underflow (1,2,4,5) and compare c/d (0,3)
    localparam logic [5:0] HAS_UNF = 6'h36;
    localparam logic [5:0] HAS_CD = 6'h09;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic unf;
        logic ovf;
        logic d;
        logic c;
        logic b;
        logic a;
    } chan_flags_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } wr_req_t;

    typedef enum logic [1:0] {
        REG_EN = 2'h0,
        REG_ST = 2'h1,
        REG_IRQ = 2'h3,
        REG_NONE = 2'h2
    } reg_kind_t;

    typedef struct packed {
        reg_kind_t kind;
        logic [2:0] idx;
    } dec_t;

    function automatic dec_t decode(input logic [7:0] a);
        dec_t d;
        d.kind = REG_NONE;
        d.idx = a[4:2];
        if (a[1:0] == 2'h0) begin
            if (a[7:5] == EN_BASE[7:5] && d.idx < NCH_IDX) begin
                d.kind = REG_EN;
            end else if (a[7:5] == ST_BASE[7:5] && d.idx < NCH_IDX) begin
                d.kind = REG_ST;
            end else if (a == IRQ_ST_OFF || a == IRQ_MASK_OFF) begin
                d.kind = REG_IRQ;
            end
        end
        return d;
    endfunction : decode

    function automatic logic [7:0] en_wmask(input int n);
        return EN_WR_COMMON | (HAS_UNF[n] ? EN_WR_UNF : 8'h00)
            | (HAS_CD[n] ? EN_WR_CD : 8'h00);
    endfunction : en_wmask
endpackage : tmr_pkg

// ===== rtl/axil_slave.sv
/*
 AXI4-Lite slave front end: takes one write and one read at a time,
 hands a write strobe and a read strobe to the register file.
 Assumes the register file answers rd_data and both errors combinationally.
*/
`timescale 1ns/1ps
`default_nettype none
module axil_slave (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // register file side
    output logic wr_stb,
    output tmr_pkg::wr_req_t wr,
    input wire logic wr_err,
    output logic rd_stb,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);
    logic aw_ok_q;
    logic w_ok_q;

    assign wr_stb = aw_ok_q & w_ok_q;
    assign rd_stb = arvalid & arready;
    assign rd_addr = araddr;

    // ready stays low until the response is taken: one write in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= tmr_pkg::RESP_OKAY;
            wr <= '0;
        end else begin
            awready <= (awready & ~awvalid) | (bvalid & bready);
            wready <= (wready & ~wvalid) | (bvalid & bready);
            if (awvalid && awready) begin
                aw_ok_q <= 1'b1;
                wr.addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_ok_q <= 1'b1;
                wr.data <= wdata;
                wr.strb <= wstrb;
            end
            if (wr_stb) begin
                aw_ok_q <= 1'b0;
                w_ok_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_err ? tmr_pkg::RESP_SLVERR : tmr_pkg::RESP_OKAY;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= tmr_pkg::RESP_OKAY;
        end else begin
            arready <= (arready & ~arvalid) | (rvalid & rready);
            if (rd_stb) begin
                rvalid <= 1'b1;
                rdata <= rd_data;
                rresp <= rd_err ? tmr_pkg::RESP_SLVERR : tmr_pkg::RESP_OKAY;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule : axil_slave
`default_nettype wire

// ===== rtl/chan_flags.sv
/*
 Status flags of one timer channel with read-then-write-zero clearing.
 Assumes set pulses and strobes come from logic on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module chan_flags #(
    parameter logic [5:0] IMPL = 6'h3f
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // flag events, one-cycle pulses
    input wire tmr_pkg::chan_flags_t set,
    // status register access
    input wire logic rd_stb,
    input wire logic wr_stb,
    input wire logic [5:0] wr_val,
    // flag state
    output var tmr_pkg::chan_flags_t flags
);
    logic [5:0] flag_q;
    logic [5:0] arm_q;
    logic [5:0] clr;

    // only bits seen as one by the last read may be cleared
    assign clr = arm_q & ~wr_val & {6{wr_stb}}; // R15
    assign flags = tmr_pkg::chan_flags_t'(flag_q);

    // set after clear: an event in the clearing cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= tmr_pkg::FLAG_RST;
        end else begin
            flag_q <= ((flag_q & ~clr) | set) & IMPL; // R15
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arm_q <= 6'h00;
        end else if (rd_stb) begin
            arm_q <= flag_q & ~clr;
        end else if (wr_stb) begin
            arm_q <= 6'h00;
        end
    end

    a_clear_only_armed: assert property (@(posedge aclk) disable iff (!aresetn) // R15
        ((~flag_q & $past(flag_q) & ~$past(clr)) == 6'h00))
        else $error("flag cleared without read then write zero");
    a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn) // R15
        ((set & IMPL) != 6'h00) |=> ((flag_q & $past(set & IMPL)) == $past(set & IMPL)))
        else $error("flag event lost");
endmodule : chan_flags
`default_nettype wire

// ===== verif/conv_irq_sink.sv
/*
 Converter trigger input seen from the timer: counts start pulses.
 Assumes pulses are synchronous to aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module conv_irq_sink (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // trigger pulses
    input wire logic [5:0] conv_start_req,
    // observed starts
    output logic [7:0] conv_cnt
);
    // counts cycles high, so a stretched pulse shows as extra starts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_cnt <= 8'h00;
        end else if (|conv_start_req) begin
            conv_cnt <= conv_cnt + 8'h01;
        end
    end
endmodule : conv_irq_sink
`default_nettype wire

// ===== verif/test_timer_irq_enable_gating.sv
/*
 Self-checking bench of the timer interrupt-enable block.
 Assumes the package is compiled first and the sink model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module test_timer_irq_enable_gating;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0] awaddr, araddr, conv_cnt;
    logic [31:0] wdata, rdata, rd_q;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp_q;
    logic [5:0][15:0] chan_counter;
    logic [5:0][3:0] cmp_evt;
    logic [5:0] unf, ovf, rq_d, rq_c, rq_b, rq_a, conv;
    int n_fail, checks_done, cyc;

    timer_irq_enable_gating timer_irq_enable_gating_inst (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .chan_counter(chan_counter),
        .cmp_evt(cmp_evt), .underflow_irq_req(unf), .overflow_irq_req(ovf),
        .cmp_d_irq_req(rq_d), .cmp_c_irq_req(rq_c), .cmp_b_irq_req(rq_b),
        .cmp_a_irq_req(rq_a), .conv_start_req(conv), .irq(irq)
    );
    conv_irq_sink conv_irq_sink_inst (.aclk(aclk), .aresetn(aresetn),
        .conv_start_req(conv), .conv_cnt(conv_cnt));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic finish_test;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    // the bench never runs longer than this
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp_q = bresp;
                break;
            end
        end
        // bready stays up: dropping it here clashes with the next call
    endtask : wr

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd_q = rdata;
                resp_q = rresp;
                break;
            end
        end
    endtask : rd

    // bits present per channel: unf, ovf, d, c, b, a
    function automatic logic [5:0] fm(input int ch);
        return 6'h13 | (tmr_pkg::HAS_UNF[ch] ? 6'h20 : 6'h00)
            | (tmr_pkg::HAS_CD[ch] ? 6'h0c : 6'h00);
    endfunction : fm

    function automatic logic [31:0] reqs(input int ch);
        return {26'h0, unf[ch], ovf[ch], rq_d[ch], rq_c[ch], rq_b[ch], rq_a[ch]};
    endfunction : reqs

    task automatic t_regs;
        for (int ch = 0; ch < 6; ch++) begin
            rd(tmr_pkg::EN_BASE + 8'(4 * ch));
            chk("enable reset", 32'h40, rd_q);
            wr(tmr_pkg::EN_BASE + 8'(4 * ch), 8'hff);
            chk("wr okay", {30'h0, tmr_pkg::RESP_OKAY}, {30'h0, resp_q});
            rd(tmr_pkg::EN_BASE + 8'(4 * ch));
            chk("enable ones", {24'h0, 2'h3, fm(ch)}, rd_q);
            wr(tmr_pkg::EN_BASE + 8'(4 * ch), 8'h00);
            rd(tmr_pkg::EN_BASE + 8'(4 * ch));
            chk("enable zeros", 32'h40, rd_q);
        end
    endtask : t_regs

    task automatic t_gate(input int ch);
        logic [7:0] en, st;
        en = tmr_pkg::EN_BASE + 8'(4 * ch);
        st = tmr_pkg::ST_BASE + 8'(4 * ch);
        cmp_evt[ch] <= 4'hf;
        chan_counter[ch] <= tmr_pkg::CNT_MAX;
        @(posedge aclk);
        cmp_evt[ch] <= 4'h0;
        chan_counter[ch] <= tmr_pkg::CNT_ZERO;
        @(posedge aclk);
        chan_counter[ch] <= tmr_pkg::CNT_MAX;
        @(posedge aclk);
        chan_counter[ch] <= 16'h1234;
        repeat (3) @(posedge aclk);
        chk("req gated", 32'h0, reqs(ch));
        // a zero write without a prior read must not clear
        wr(st, 8'h00);
        wr(en, 8'h3f);
        repeat (3) @(posedge aclk);
        chk("req on", {26'h0, fm(ch)}, reqs(ch));
        rd(st);
        chk("status", {24'h0, 2'h3, fm(ch)}, rd_q);
        wr(st, 8'h00);
        @(posedge aclk);
        chk("req drop", 32'h0, reqs(ch));
        wr(en, 8'h00);
    endtask : t_gate

    task automatic t_summary;
        rd(tmr_pkg::IRQ_ST_OFF);
        chk("pending", 32'h3f, rd_q);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(tmr_pkg::IRQ_MASK_OFF, 8'h01);
        repeat (2) @(posedge aclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(tmr_pkg::IRQ_ST_OFF, 8'h3f);
        repeat (2) @(posedge aclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
    endtask : t_summary

    task automatic t_conv;
        for (int k = 0; k < 2; k++) begin
            wr(tmr_pkg::EN_BASE + 8'h08, k == 0 ? 8'h81 : 8'h00);
            cmp_evt[2] <= 4'h1;
            @(posedge aclk);
            cmp_evt[2] <= 4'h0;
            repeat (3) @(posedge aclk);
            chk("conv starts", 32'h1, {24'h0, conv_cnt});
            chk("a req", k == 0 ? 32'h1 : 32'h0, {31'h0, rq_a[2]});
        end
    endtask : t_conv

    task automatic t_bad;
        rd(8'h18);
        chk("bad rd resp", {30'h0, tmr_pkg::RESP_SLVERR}, {30'h0, resp_q});
        chk("bad rd data", 32'h0, rd_q);
        wr(8'h18, 8'hff);
        chk("bad wr resp", {30'h0, tmr_pkg::RESP_SLVERR}, {30'h0, resp_q});
        // low byte strobe off: the write must not land
        wstrb <= 4'he;
        wr(tmr_pkg::EN_BASE, 8'hff);
        wstrb <= 4'hf;
        rd(tmr_pkg::EN_BASE);
        chk("strobe off", 32'h40, rd_q);
    endtask : t_bad

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hf;
        chan_counter = {6{16'h1234}};
        cmp_evt = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        for (int ch = 0; ch < 6; ch++) begin
            t_gate(ch);
        end
        t_summary();
        t_conv();
        t_bad();
        finish_test();
    end
endmodule : test_timer_irq_enable_gating
`default_nettype wire
